// ===== src/cmr_pkg.sv
// Package for the comparator mode and control register bank.
// Assumes an 8-bit special function register bus in the system clock domain.
package cmr_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] CMR_ADDR_CMP1_CONTROL = 8'h9a;
	localparam logic [7:0] CMR_ADDR_CMP1_MODE = 8'h9c;
	localparam logic [7:0] CMR_ADDR_CMP0_MODE = 8'h9d;
	localparam logic [7:0] CMR_ADDR_CMP1_MUX = 8'h9e;
	localparam logic [7:0] CMR_ADDR_CMP0_MUX = 8'h9f;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CMR_CTL_ENABLE_BIT = 7;
	localparam int CMR_CTL_OUTPUT_BIT = 6;
	localparam int CMR_CTL_RISE_FLAG_BIT = 5;
	localparam int CMR_CTL_FALL_FLAG_BIT = 4;
	localparam int CMR_CTL_POS_HYST_LSB = 2;
	localparam int CMR_CTL_NEG_HYST_LSB = 0;

	// ****************************************
	// Mode register fields
	// ****************************************
	localparam int CMR_MD_RISE_IE_BIT = 5;
	localparam int CMR_MD_FALL_IE_BIT = 4;
	localparam int CMR_MD_MODE_LSB = 0;

	// ****************************************
	// Input select fields
	// ****************************************
	localparam int CMR_MX_NEG_LSB = 4;
	localparam int CMR_MX_POS_LSB = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0] CMR_HYST_RESET = 2'h0;
	localparam logic [1:0] CMR_MODE_RESET = 2'h2;
	localparam logic [2:0] CMR_SEL_RESET = 3'h0;
	localparam logic [7:0] CMR_READ_NONE = 8'h00;

endpackage : cmr_pkg

// ===== src/cmr_sync_edge.sv
// Two-flop synchronizer with rising and falling edge detect.
// Assumes an asynchronous level input and one system clock.
`timescale 1ns/1ps

module cmr_sync_edge
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic async_in,
	output logic level,
	output logic rise,
	output logic fall
);

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// ****************************************
	// Synchronizer; only sync_reg reads meta_reg
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~prev_reg;
	assign fall = ~sync_reg & prev_reg;

endmodule : cmr_sync_edge

// ===== src/cmr_regs.sv
// Comparator mode, control and input select registers on the SFR bus.
// Assumes the first comparator's edge flags arrive from logic on the same clock.
//
// Function
// - Control bit 7 enables comparator one
// - Control bit 6 reads synchronized output, read-only
// - Bit 5 latches rising edge until cleared
// - Bit 4 latches falling edge until cleared
// - Bits 3:2 select positive hysteresis level
// - Bits 1:0 select negative hysteresis, reset 00
// - Comparator zero mode bit 5 enables rise interrupt
// - Comparator zero mode bit 4 enables fall interrupt
// - Comparator one mode bits 5, 4 likewise
// - Comparator zero mode bits 1:0 response, reset 10
// - Comparator one mode bits 1:0 response, reset 10
// - Unused mode bits read zero, ignore writes
// - Three-bit positive and negative input selects
// - Output transition sets matching edge flag while comparator one is enabled
// - Disabled comparator drives port output low
// - Interrupt when edge flag and enable set
`timescale 1ns/1ps

module cmr_regs
	import cmr_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic cmp1_raw_out,
	input wire logic cmp0_rise_flag,
	input wire logic cmp0_fall_flag,
	output logic cmp1_enable,
	output logic [1:0] cmp1_pos_hysteresis,
	output logic [1:0] cmp1_neg_hysteresis,
	output logic [1:0] cmp0_response_mode,
	output logic [1:0] cmp1_response_mode,
	output logic [2:0] cmp0_positive_input_select,
	output logic [2:0] cmp0_negative_input_select,
	output logic [2:0] cmp1_positive_input_select,
	output logic [2:0] cmp1_negative_input_select,
	output logic cmp1_port_out,
	output logic cmp0_irq,
	output logic cmp1_irq
);

	// ****************************************
	// State
	// ****************************************
	logic cmp1_enable_reg, cmp1_enable_next;
	logic cmp1_output_state_reg, cmp1_output_state_next;
	logic cmp1_rise_flag_reg, cmp1_rise_flag_next;
	logic cmp1_fall_flag_reg, cmp1_fall_flag_next;
	logic [1:0] cmp1_pos_hysteresis_reg, cmp1_pos_hysteresis_next;
	logic [1:0] cmp1_neg_hysteresis_reg, cmp1_neg_hysteresis_next;
	logic cmp0_rise_irq_en_reg, cmp0_rise_irq_en_next;
	logic cmp0_fall_irq_en_reg, cmp0_fall_irq_en_next;
	logic [1:0] cmp0_response_mode_reg, cmp0_response_mode_next;
	logic cmp1_rise_irq_en_reg, cmp1_rise_irq_en_next;
	logic cmp1_fall_irq_en_reg, cmp1_fall_irq_en_next;
	logic [1:0] cmp1_response_mode_reg, cmp1_response_mode_next;
	logic [2:0] cmp0_pos_sel_reg, cmp0_pos_sel_next;
	logic [2:0] cmp0_neg_sel_reg, cmp0_neg_sel_next;
	logic [2:0] cmp1_pos_sel_reg, cmp1_pos_sel_next;
	logic [2:0] cmp1_neg_sel_reg, cmp1_neg_sel_next;
	logic [7:0] sfr_rdata_reg, sfr_rdata_next;
	logic cmp1_port_out_reg, cmp1_port_out_next;
	logic cmp0_irq_reg, cmp0_irq_next;
	logic cmp1_irq_reg, cmp1_irq_next;

	logic sync_level;
	logic sync_rise;
	logic sync_fall;
	logic wr_ctl1;
	logic wr_md1;
	logic wr_md0;
	logic wr_mx1;
	logic wr_mx0;

	// ****************************************
	// Comparator output synchronizer
	// ****************************************
	// The raw output is asynchronous; it crosses into the clock domain here and nowhere else
	cmr_sync_edge u_sync
	(
		.clk(clk),
		.rstn(rstn),
		.async_in(cmp1_raw_out),
		.level(sync_level),
		.rise(sync_rise),
		.fall(sync_fall)
	);

	// Mode registers share one layout; unused bits always read zero
	function automatic logic [7:0] mode_image(input logic rie, input logic fie, input logic [1:0] md);
		logic [7:0] img;
		img = 8'h00;
		img[CMR_MD_RISE_IE_BIT] = rie;
		img[CMR_MD_FALL_IE_BIT] = fie;
		img[CMR_MD_MODE_LSB +: 2] = md;
		return img;
	endfunction : mode_image

	function automatic logic [7:0] mux_image(input logic [2:0] neg, input logic [2:0] pos);
		logic [7:0] img;
		img = 8'h00;
		img[CMR_MX_NEG_LSB +: 3] = neg;
		img[CMR_MX_POS_LSB +: 3] = pos;
		return img;
	endfunction : mux_image

	// Full address decode; a write to an unmapped address is simply dropped
	assign wr_ctl1 = sfr_wr && (sfr_addr == CMR_ADDR_CMP1_CONTROL);
	assign wr_md1 = sfr_wr && (sfr_addr == CMR_ADDR_CMP1_MODE);
	assign wr_md0 = sfr_wr && (sfr_addr == CMR_ADDR_CMP0_MODE);
	assign wr_mx1 = sfr_wr && (sfr_addr == CMR_ADDR_CMP1_MUX);
	assign wr_mx0 = sfr_wr && (sfr_addr == CMR_ADDR_CMP0_MUX);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		cmp1_enable_next = cmp1_enable_reg;
		cmp1_pos_hysteresis_next = cmp1_pos_hysteresis_reg;
		cmp1_neg_hysteresis_next = cmp1_neg_hysteresis_reg;
		cmp1_rise_flag_next = cmp1_rise_flag_reg;
		cmp1_fall_flag_next = cmp1_fall_flag_reg;
		if (wr_ctl1)
		begin
			cmp1_enable_next = sfr_wdata[CMR_CTL_ENABLE_BIT];
			cmp1_rise_flag_next = sfr_wdata[CMR_CTL_RISE_FLAG_BIT];
			cmp1_fall_flag_next = sfr_wdata[CMR_CTL_FALL_FLAG_BIT];
			cmp1_pos_hysteresis_next = sfr_wdata[CMR_CTL_POS_HYST_LSB +: 2];
			cmp1_neg_hysteresis_next = sfr_wdata[CMR_CTL_NEG_HYST_LSB +: 2];
		end
		// Edge wins over a clear in the same cycle so no event is lost
		if (cmp1_enable_reg && sync_rise)
		begin
			cmp1_rise_flag_next = 1'b1;
		end
		if (cmp1_enable_reg && sync_fall)
		begin
			cmp1_fall_flag_next = 1'b1;
		end
		// Bit 6 ignores writes and follows the synchronized output
		cmp1_output_state_next = sync_level;

		cmp0_rise_irq_en_next = cmp0_rise_irq_en_reg;
		cmp0_fall_irq_en_next = cmp0_fall_irq_en_reg;
		cmp0_response_mode_next = cmp0_response_mode_reg;
		if (wr_md0)
		begin
			cmp0_rise_irq_en_next = sfr_wdata[CMR_MD_RISE_IE_BIT];
			cmp0_fall_irq_en_next = sfr_wdata[CMR_MD_FALL_IE_BIT];
			cmp0_response_mode_next = sfr_wdata[CMR_MD_MODE_LSB +: 2];
		end

		cmp1_rise_irq_en_next = cmp1_rise_irq_en_reg;
		cmp1_fall_irq_en_next = cmp1_fall_irq_en_reg;
		cmp1_response_mode_next = cmp1_response_mode_reg;
		if (wr_md1)
		begin
			cmp1_rise_irq_en_next = sfr_wdata[CMR_MD_RISE_IE_BIT];
			cmp1_fall_irq_en_next = sfr_wdata[CMR_MD_FALL_IE_BIT];
			cmp1_response_mode_next = sfr_wdata[CMR_MD_MODE_LSB +: 2];
		end

		cmp0_pos_sel_next = cmp0_pos_sel_reg;
		cmp0_neg_sel_next = cmp0_neg_sel_reg;
		if (wr_mx0)
		begin
			cmp0_pos_sel_next = sfr_wdata[CMR_MX_POS_LSB +: 3];
			cmp0_neg_sel_next = sfr_wdata[CMR_MX_NEG_LSB +: 3];
		end
		cmp1_pos_sel_next = cmp1_pos_sel_reg;
		cmp1_neg_sel_next = cmp1_neg_sel_reg;
		if (wr_mx1)
		begin
			cmp1_pos_sel_next = sfr_wdata[CMR_MX_POS_LSB +: 3];
			cmp1_neg_sel_next = sfr_wdata[CMR_MX_NEG_LSB +: 3];
		end

		// Read data is held until the next read; unmapped addresses answer zero
		sfr_rdata_next = sfr_rdata_reg;
		if (sfr_rd)
		begin
			unique case (sfr_addr)
				CMR_ADDR_CMP1_CONTROL:
				begin
					sfr_rdata_next = {cmp1_enable_reg, cmp1_output_state_reg, cmp1_rise_flag_reg,
						cmp1_fall_flag_reg, cmp1_pos_hysteresis_reg, cmp1_neg_hysteresis_reg};
				end
				CMR_ADDR_CMP1_MODE:
				begin
					sfr_rdata_next = mode_image(cmp1_rise_irq_en_reg, cmp1_fall_irq_en_reg,
						cmp1_response_mode_reg);
				end
				CMR_ADDR_CMP0_MODE:
				begin
					sfr_rdata_next = mode_image(cmp0_rise_irq_en_reg, cmp0_fall_irq_en_reg,
						cmp0_response_mode_reg);
				end
				CMR_ADDR_CMP1_MUX:
				begin
					sfr_rdata_next = mux_image(cmp1_neg_sel_reg, cmp1_pos_sel_reg);
				end
				CMR_ADDR_CMP0_MUX:
				begin
					sfr_rdata_next = mux_image(cmp0_neg_sel_reg, cmp0_pos_sel_reg);
				end
				default:
				begin
					sfr_rdata_next = CMR_READ_NONE;
				end
			endcase
		end

		// Output to the pin is low while powered down, not a stale level
		cmp1_port_out_next = cmp1_enable_reg & cmp1_output_state_reg;
		cmp0_irq_next = (cmp0_rise_flag & cmp0_rise_irq_en_reg) | (cmp0_fall_flag & cmp0_fall_irq_en_reg);
		cmp1_irq_next = (cmp1_rise_flag_reg & cmp1_rise_irq_en_reg)
			| (cmp1_fall_flag_reg & cmp1_fall_irq_en_reg);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp1_enable_reg <= 1'b0;
			cmp1_output_state_reg <= 1'b0;
			cmp1_rise_flag_reg <= 1'b0;
			cmp1_fall_flag_reg <= 1'b0;
			cmp1_pos_hysteresis_reg <= CMR_HYST_RESET;
			cmp1_neg_hysteresis_reg <= CMR_HYST_RESET;
			cmp0_rise_irq_en_reg <= 1'b0;
			cmp0_fall_irq_en_reg <= 1'b0;
			cmp0_response_mode_reg <= CMR_MODE_RESET;
			cmp1_rise_irq_en_reg <= 1'b0;
			cmp1_fall_irq_en_reg <= 1'b0;
			cmp1_response_mode_reg <= CMR_MODE_RESET;
			cmp0_pos_sel_reg <= CMR_SEL_RESET;
			cmp0_neg_sel_reg <= CMR_SEL_RESET;
			cmp1_pos_sel_reg <= CMR_SEL_RESET;
			cmp1_neg_sel_reg <= CMR_SEL_RESET;
			sfr_rdata_reg <= CMR_READ_NONE;
			cmp1_port_out_reg <= 1'b0;
			cmp0_irq_reg <= 1'b0;
			cmp1_irq_reg <= 1'b0;
		end
		else
		begin
			cmp1_enable_reg <= cmp1_enable_next;
			cmp1_output_state_reg <= cmp1_output_state_next;
			cmp1_rise_flag_reg <= cmp1_rise_flag_next;
			cmp1_fall_flag_reg <= cmp1_fall_flag_next;
			cmp1_pos_hysteresis_reg <= cmp1_pos_hysteresis_next;
			cmp1_neg_hysteresis_reg <= cmp1_neg_hysteresis_next;
			cmp0_rise_irq_en_reg <= cmp0_rise_irq_en_next;
			cmp0_fall_irq_en_reg <= cmp0_fall_irq_en_next;
			cmp0_response_mode_reg <= cmp0_response_mode_next;
			cmp1_rise_irq_en_reg <= cmp1_rise_irq_en_next;
			cmp1_fall_irq_en_reg <= cmp1_fall_irq_en_next;
			cmp1_response_mode_reg <= cmp1_response_mode_next;
			cmp0_pos_sel_reg <= cmp0_pos_sel_next;
			cmp0_neg_sel_reg <= cmp0_neg_sel_next;
			cmp1_pos_sel_reg <= cmp1_pos_sel_next;
			cmp1_neg_sel_reg <= cmp1_neg_sel_next;
			sfr_rdata_reg <= sfr_rdata_next;
			cmp1_port_out_reg <= cmp1_port_out_next;
			cmp0_irq_reg <= cmp0_irq_next;
			cmp1_irq_reg <= cmp1_irq_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Every output is a register so the analog side never sees decode glitches
	assign sfr_rdata = sfr_rdata_reg;
	assign cmp1_enable = cmp1_enable_reg;
	assign cmp1_pos_hysteresis = cmp1_pos_hysteresis_reg;
	assign cmp1_neg_hysteresis = cmp1_neg_hysteresis_reg;
	assign cmp0_response_mode = cmp0_response_mode_reg;
	assign cmp1_response_mode = cmp1_response_mode_reg;
	assign cmp0_positive_input_select = cmp0_pos_sel_reg;
	assign cmp0_negative_input_select = cmp0_neg_sel_reg;
	assign cmp1_positive_input_select = cmp1_pos_sel_reg;
	assign cmp1_negative_input_select = cmp1_neg_sel_reg;
	assign cmp1_port_out = cmp1_port_out_reg;
	assign cmp0_irq = cmp0_irq_reg;
	assign cmp1_irq = cmp1_irq_reg;

endmodule : cmr_regs

// ===== tb/cmr_cmp_model.sv
// Behavioural analog comparator driving the raw output of comparator one.
// Assumes millivolt levels from the bench; the output moves off the clock edge.
`timescale 1ns/1ps

module cmr_cmp_model
(
	input wire logic [9:0] pos_mv,
	input wire logic [9:0] neg_mv,
	output wire logic raw_out
);
	// Delay keeps the raw edge away from the sampling clock edge
	assign #7 raw_out = pos_mv > neg_mv;
endmodule : cmr_cmp_model

// ===== tb/cmr_regs_asserts.sv
// Concurrent checks on the comparator register bank ports.
// Assumes binding to cmr_regs with one clock and active-low reset.
`timescale 1ns/1ps

module cmr_regs_asserts
	import cmr_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic cmp1_raw_out,
	input wire logic cmp0_rise_flag,
	input wire logic cmp0_fall_flag,
	input wire logic cmp1_enable,
	input wire logic [1:0] cmp1_pos_hysteresis,
	input wire logic [1:0] cmp1_neg_hysteresis,
	input wire logic [1:0] cmp0_response_mode,
	input wire logic [1:0] cmp1_response_mode,
	input wire logic cmp1_port_out,
	input wire logic cmp0_irq
);
	// ****************************************
	// Sequences
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_wr(logic [7:0] a); sfr_wr && sfr_addr == a; endsequence
	sequence s_rd(logic [7:0] a); sfr_rd && sfr_addr == a; endsequence
	// Five samples: two-flop chain, state bit, and the flops still held at the release edge
	sequence s_hi_run; cmp1_raw_out [*5]; endsequence
	sequence s_lo_run; !cmp1_raw_out [*5]; endsequence
	// ****************************************
	// Properties
	// ****************************************
	AST_ENABLE_WR: assert property (s_wr(CMR_ADDR_CMP1_CONTROL) |=> cmp1_enable == $past(sfr_wdata[7]))
		else $error("enable bit not taken from write");
	AST_HYST_WR: assert property (s_wr(CMR_ADDR_CMP1_CONTROL) |=>
		{cmp1_pos_hysteresis, cmp1_neg_hysteresis} == $past(sfr_wdata[3:0]))
		else $error("hysteresis fields not taken from write");
	AST_MODE0_WR: assert property (s_wr(CMR_ADDR_CMP0_MODE) |=> cmp0_response_mode == $past(sfr_wdata[1:0]))
		else $error("comparator zero mode not taken from write");
	AST_MODE1_WR: assert property (s_wr(CMR_ADDR_CMP1_MODE) |=> cmp1_response_mode == $past(sfr_wdata[1:0]))
		else $error("comparator one mode not taken from write");
	AST_MODE_UNUSED: assert property ((s_rd(CMR_ADDR_CMP0_MODE) or s_rd(CMR_ADDR_CMP1_MODE)) |=>
		sfr_rdata[7:6] == 2'h0 && sfr_rdata[3:2] == 2'h0)
		else $error("unused mode bits read nonzero");
	AST_OUT_HIGH: assert property (s_hi_run ##0 s_rd(CMR_ADDR_CMP1_CONTROL) |=> sfr_rdata[6])
		else $error("output state bit low while input high");
	AST_OUT_LOW: assert property (s_lo_run ##0 s_rd(CMR_ADDR_CMP1_CONTROL) |=> !sfr_rdata[6])
		else $error("output state bit high while input low");
	AST_PORT_LOW: assert property (!cmp1_enable [*2] |-> !cmp1_port_out)
		else $error("port output high while disabled");
	AST_IRQ0_CAUSE: assert property (cmp0_irq |-> $past(cmp0_rise_flag || cmp0_fall_flag))
		else $error("comparator zero interrupt without a flag");
	AST_RDATA_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
endmodule : cmr_regs_asserts

// ===== tb/cmr_regs_tb.sv
// Self-checking bench for the comparator register bank.
// Assumes the analog comparator model and the assertion checker beside it.
`timescale 1ns/1ps

module cmr_regs_tb;
	import cmr_pkg::*;
	logic clk, rstn, sfr_wr, sfr_rd, cmp0_rise_flag, cmp0_fall_flag;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [9:0] pos_mv, neg_mv;
	wire logic cmp1_raw_out;
	logic cmp1_enable, cmp1_port_out, cmp0_irq, cmp1_irq;
	logic [1:0] cmp1_pos_hysteresis, cmp1_neg_hysteresis, cmp0_response_mode, cmp1_response_mode;
	logic [2:0] p0, n0, p1, n1;
	int err_total, checked;

	cmr_regs u_dut (.clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .cmp1_raw_out,
		.cmp0_rise_flag, .cmp0_fall_flag, .cmp1_enable, .cmp1_pos_hysteresis, .cmp1_neg_hysteresis,
		.cmp0_response_mode, .cmp1_response_mode, .cmp0_positive_input_select(p0),
		.cmp0_negative_input_select(n0), .cmp1_positive_input_select(p1),
		.cmp1_negative_input_select(n1), .cmp1_port_out, .cmp0_irq, .cmp1_irq);
	cmr_cmp_model u_cmp (.pos_mv, .neg_mv, .raw_out(cmp1_raw_out));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1;
		chk("sfr_rdata", exp, sfr_rdata);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic complete_run;
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rd(CMR_ADDR_CMP1_CONTROL, 8'h00);
		rd(CMR_ADDR_CMP1_MODE, 8'h02);
		rd(CMR_ADDR_CMP0_MODE, 8'h02);
		rd(CMR_ADDR_CMP1_MUX, 8'h00);
		rd(8'h90, 8'h00);
	endtask : t_reset

	task automatic t_codes;
		for (int i = 0; i < 4; i++)
		begin
			wr(CMR_ADDR_CMP1_CONTROL, {4'h8, i[1:0], ~i[1:0]});
			chk("hyst", {4'h8, i[1:0], ~i[1:0]},
				{cmp1_enable, 3'h0, cmp1_pos_hysteresis, cmp1_neg_hysteresis});
			rd(CMR_ADDR_CMP1_CONTROL, {4'h8, i[1:0], ~i[1:0]});
			wr(CMR_ADDR_CMP1_MODE, {6'h3f, i[1:0]});
			wr(CMR_ADDR_CMP0_MODE, {6'h3f, ~i[1:0]});
			chk("modes", {4'h0, i[1:0], ~i[1:0]}, {4'h0, cmp1_response_mode, cmp0_response_mode});
			rd(CMR_ADDR_CMP1_MODE, {6'h0c, i[1:0]} & 8'h33);
		end
		wr(CMR_ADDR_CMP1_CONTROL, 8'h40);
		rd(CMR_ADDR_CMP1_CONTROL, 8'h00);
	endtask : t_codes

	task automatic t_edges;
		wr(CMR_ADDR_CMP1_MODE, 8'h30);
		wr(CMR_ADDR_CMP1_CONTROL, 8'h80);
		pos_mv <= 10'd300;
		settle(6);
		rd(CMR_ADDR_CMP1_CONTROL, 8'he0);
		chk("irq_port", 8'h03, {6'h0, cmp1_irq, cmp1_port_out});
		wr(CMR_ADDR_CMP1_MODE, 8'h10);
		settle(2);
		chk("irq_masked", 8'h00, {7'h0, cmp1_irq});
		wr(CMR_ADDR_CMP1_MODE, 8'h30);
		wr(CMR_ADDR_CMP1_CONTROL, 8'h80);
		settle(2);
		chk("irq_cleared", 8'h00, {7'h0, cmp1_irq});
		pos_mv <= 10'd0;
		settle(6);
		rd(CMR_ADDR_CMP1_CONTROL, 8'h90);
		chk("irq_port", 8'h02, {6'h0, cmp1_irq, cmp1_port_out});
		wr(CMR_ADDR_CMP1_CONTROL, 8'h00);
		pos_mv <= 10'd300;
		settle(6);
		rd(CMR_ADDR_CMP1_CONTROL, 8'h40);
		chk("port_off", 8'h00, {6'h0, cmp1_irq, cmp1_port_out});
	endtask : t_edges

	task automatic t_cmp0;
		wr(CMR_ADDR_CMP0_MODE, 8'h20);
		@(posedge clk);
		cmp0_rise_flag <= 1'b1;
		settle(3);
		chk("cmp0_irq", 8'h01, {7'h0, cmp0_irq});
		@(posedge clk);
		cmp0_rise_flag <= 1'b0;
		cmp0_fall_flag <= 1'b1;
		settle(3);
		chk("cmp0_irq", 8'h00, {7'h0, cmp0_irq});
		wr(CMR_ADDR_CMP0_MODE, 8'h10);
		settle(2);
		chk("cmp0_irq", 8'h01, {7'h0, cmp0_irq});
		@(posedge clk);
		cmp0_fall_flag <= 1'b0;
	endtask : t_cmp0

	task automatic t_mux;
		wr(CMR_ADDR_CMP1_MUX, 8'hff);
		rd(CMR_ADDR_CMP1_MUX, 8'h77);
		wr(CMR_ADDR_CMP0_MUX, 8'h35);
		chk("mux0", 8'h35, {1'b0, n0, 1'b0, p0});
		chk("mux1", 8'h77, {1'b0, n1, 1'b0, p1});
		rd(CMR_ADDR_CMP0_MUX, 8'h35);
	endtask : t_mux

	// Mid-run reset with the raw input high: flags clear and no false edge is flagged
	task automatic t_rerst;
		wr(CMR_ADDR_CMP1_CONTROL, 8'hb0);
		settle(1);
		chk("irq_written", 8'h01, {7'h0, cmp1_irq});
		@(posedge clk);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(CMR_ADDR_CMP0_MUX, 8'h00);
		rd(CMR_ADDR_CMP1_MODE, 8'h02);
		rd(CMR_ADDR_CMP0_MODE, 8'h02);
		rd(CMR_ADDR_CMP1_CONTROL, 8'h40);
		chk("irq_port_rst", 8'h00, {6'h0, cmp1_irq, cmp1_port_out});
	endtask : t_rerst

	initial
	begin
		{rstn, sfr_wr, sfr_rd, cmp0_rise_flag, cmp0_fall_flag} = 5'h0;
		{sfr_addr, sfr_wdata} = 16'h0;
		pos_mv = 10'd100;
		neg_mv = 10'd200;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_codes();
		t_edges();
		t_cmp0();
		t_mux();
		t_rerst();
		complete_run();
	end

	// Whole run needs about 135 cycles; this allows nearly fifteen times that
	initial
	begin
		#40000;
		err_total++;
		complete_run();
	end
endmodule : cmr_regs_tb

bind cmr_regs cmr_regs_asserts u_chk (.clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
	.cmp1_raw_out, .cmp0_rise_flag, .cmp0_fall_flag, .cmp1_enable, .cmp1_pos_hysteresis,
	.cmp1_neg_hysteresis, .cmp0_response_mode, .cmp1_response_mode, .cmp1_port_out, .cmp0_irq);
